// ---- hdl/phy_receive_mac_interface.sv ----
// Receive-side MAC interface: presents decoded receive symbols to a MAC in
// MII, RMII master/slave/repeater or RGMII form, sources the receive clock,
// relays management pin bits and serves the power-down/interrupt pin.
// Assumes SYM_* come from the decoder on CLK; pins are asynchronous.
// Behaviour
// - Management clock may be unrelated; cross internally.
// - Data changes on receive clock rise.
// - Four bits in MII, two in RMII.
// - RMII valid pin carries carrier or valid.
// - Repeater mode makes the pin pure valid.
// - RGMII control: valid on rise, error on fall.
// - MII drives recovered 2.5 MHz receive clock.
// - RMII master drives reference clock on pin.
// - RMII slave leaves receive clock pin undriven.
// - RGMII drives recovered 2.5 MHz receive clock.
// - MII error high on receive clock rise.
// - RMII error aligned to reference clock rise.
// - Every error flagged, idle ones too.
// - RGMII never uses the error pin.
// - Shared pin is power-down input after reset.
// - Low on power-down pin powers down.
// - Interrupt pulls pin low, open drain.
// - Management data line driven by one side.
`include "phy_rx_consts.svh"
module phy_receive_mac_interface
  import phy_rx_pkg::*;
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic [1:0] MAC_MODE,
  input wire logic REPEATER_SEL,
  input wire logic SYM_VALID,
  input wire logic [`NIB_W-1:0] SYM_DATA,
  input wire logic SYM_ERR,
  input wire logic SYM_CARRIER,
  input wire logic RMII_REF_IN,
  output logic RX_CLK_PIN_OUT,
  output logic RX_CLK_PIN_OE,
  output logic [`NIB_W-1:0] RX_D,
  output logic RX_DV,
  output logic RX_ER,
  input wire logic MDC,
  input wire logic MDIO_IN,
  output logic MDIO_OUT,
  output logic MDIO_OE,
  input wire logic MGMT_DRIVE,
  input wire logic MGMT_OUT_BIT,
  output logic MGMT_BIT,
  output logic MGMT_BIT_VALID,
  input wire logic IRQ_PIN_MODE,
  input wire logic IRQ_PENDING,
  input wire logic POWER_DOWN_OR_IRQ_PIN_IN,
  output logic POWER_DOWN_OR_IRQ_PIN_OUT,
  output logic POWER_DOWN_OR_IRQ_PIN_OE,
  output logic POWER_DOWN
);

  localparam int RX_HALF = `RXCLK_HALF;
  localparam int RM_HALF = `RMII_HALF;

  mac_mode_e mode;
  dibit_phase_e phase_q;
  logic [`SYNC_W-1:0] s_lvl, s_rise, s_fall;
  logic rx_clk, rx_rise, rx_fall;
  logic rmii_master_ref_clock_out, rm_rise, rm_fall;
  logic tick_r, tick_f, is_rmii, consume;
  logic [`NIB_W-1:0] hold_q;
  logic hold_full_q, err_pend_q, rgmii_er_q;
  logic [`NIB_W-1:0] rx_d_q;
  logic rx_dv_q, rx_er_q, clk_pin_q, clk_oe_q;
  logic mdio_out_q, mdio_oe_q, mgmt_bit_q, mgmt_vld_q;
  logic pwr_oe_q, pwr_out_q, pd_q;

  assign mode = mac_mode_e'(MAC_MODE);
  assign is_rmii = (mode == MODE_RMII_MASTER) || (mode == MODE_RMII_SLAVE);

  // All pins from outside the clock domain pass two flops first. The
  // shared pin enters inverted, so the cleared flops read a released pin.
  pin_sync #(.W(`SYNC_W)) u_sync (
    .clk(CLK),
    .resetn(RESETN),
    .ce(CE),
    .pin_in({~POWER_DOWN_OR_IRQ_PIN_IN, RMII_REF_IN, MDIO_IN, MDC}),
    .level(s_lvl),
    .rise(s_rise),
    .fall(s_fall)
  );

  // Recovered 2.5 MHz receive clock for MII and RGMII.
  clk_div #(.HALF(RX_HALF)) u_rxdiv (
    .clk(CLK),
    .resetn(RESETN),
    .ce(CE),
    .clk_q(rx_clk),
    .rise_q(rx_rise),
    .fall_q(rx_fall)
  );

  // RMII master reference; the core clock caps it at half its own rate.
  clk_div #(.HALF(RM_HALF)) u_rmdiv (
    .clk(CLK),
    .resetn(RESETN),
    .ce(CE),
    .clk_q(rmii_master_ref_clock_out),
    .rise_q(rm_rise),
    .fall_q(rm_fall)
  );

  // Pick the edge strobes of whichever clock times the MAC side.
  always_comb begin
    case (mode)
      MODE_MII: begin
        tick_r = rx_rise;
        tick_f = 1'b0;
      end
      MODE_RGMII: begin
        tick_r = rx_rise;
        tick_f = rx_fall;
      end
      MODE_RMII_MASTER: begin
        tick_r = rm_rise;
        tick_f = rm_fall;
      end
      MODE_RMII_SLAVE: begin
        tick_r = s_rise[`SY_REF];
        tick_f = 1'b0;
      end
      default: begin
        tick_r = 1'b0;
        tick_f = 1'b0;
      end
    endcase
  end

  // The receive clock pin follows the divider one cycle late, the same
  // delay the data registers see, so data changes with the rising edge.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      clk_pin_q <= 1'b0;
      clk_oe_q <= 1'b0;
    end else if (CE) begin
      case (mode)
        MODE_MII, MODE_RGMII: begin
          clk_pin_q <= rx_clk;
          clk_oe_q <= 1'b1;
        end
        MODE_RMII_MASTER: begin
          clk_pin_q <= rmii_master_ref_clock_out;
          clk_oe_q <= 1'b1;
        end
        default: begin
          clk_pin_q <= 1'b0;
          clk_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // A nibble is used up at once in MII/RGMII, after two dibits in RMII.
  assign consume = tick_r && hold_full_q && (!is_rmii || phase_q == PH_HIGH);

  // One decoded nibble is held until the MAC-side clock takes it. A new
  // symbol in the consuming cycle wins, so none is dropped at the seam.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      hold_q <= '0;
      hold_full_q <= 1'b0;
    end else if (CE) begin
      if (SYM_VALID) begin
        hold_q <= SYM_DATA;
        hold_full_q <= 1'b1;
      end else if (consume) begin
        hold_full_q <= 1'b0;
      end
    end
  end

  // Errors are sticky until reported; a new error beats the clear.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      err_pend_q <= 1'b0;
    end else if (CE) begin
      if (SYM_ERR) begin
        err_pend_q <= 1'b1;
      end else if (tick_r) begin
        err_pend_q <= 1'b0;
      end
    end
  end

  // Dibit phase: low pair first, then high pair of the held nibble.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      phase_q <= PH_LOW;
    end else if (CE) begin
      if (!is_rmii) begin
        phase_q <= PH_LOW;
      end else if (tick_r && hold_full_q) begin
        phase_q <= (phase_q == PH_LOW) ? PH_HIGH : PH_LOW;
      end
    end
  end

  // Receive data and data valid, updated on the MAC-side rising tick; in RGMII valid also takes the error flag on the falling tick.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rx_d_q <= '0;
      rx_dv_q <= 1'b0;
      rgmii_er_q <= 1'b0;
    end else if (CE) begin
      if (tick_r) begin
        rgmii_er_q <= (mode == MODE_RGMII) && err_pend_q;
        if (!hold_full_q) begin
          rx_d_q <= '0;
          rx_dv_q <= is_rmii && !REPEATER_SEL && SYM_CARRIER;
        end else if (!is_rmii) begin
          rx_d_q <= hold_q;
          rx_dv_q <= 1'b1;
        end else begin
          rx_d_q <= (phase_q == PH_LOW) ? {2'b00, hold_q[1:0]}
                                         : {2'b00, hold_q[3:2]};
          rx_dv_q <= 1'b1;
        end
      end else if (tick_f && mode == MODE_RGMII) begin
        rx_dv_q <= rgmii_er_q;
      end
    end
  end

  // Dedicated error pin: MII and RMII only, RGMII keeps it low throughout.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rx_er_q <= 1'b0;
    end else if (CE) begin
      if (mode == MODE_RGMII) begin
        rx_er_q <= 1'b0;
      end else if (tick_r) begin
        rx_er_q <= err_pend_q;
      end
    end
  end

  // Management pins: a bit is sampled on each synchronised clock rise and
  // our bit goes out on the fall, so the station samples a settled line.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      mgmt_bit_q <= 1'b0;
      mgmt_vld_q <= 1'b0;
      mdio_out_q <= 1'b0;
      mdio_oe_q <= 1'b0;
    end else if (CE) begin
      mgmt_vld_q <= s_rise[`SY_MDC];
      if (s_rise[`SY_MDC]) begin
        mgmt_bit_q <= s_lvl[`SY_MDIO];
      end
      if (s_fall[`SY_MDC]) begin
        mdio_out_q <= MGMT_OUT_BIT;
        mdio_oe_q <= MGMT_DRIVE;
      end
    end
  end

  // Shared pin: power-down input unless told otherwise, which resets clear.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      pwr_oe_q <= 1'b0;
      pwr_out_q <= 1'b0;
      pd_q <= 1'b0;
    end else if (CE) begin
      pwr_out_q <= 1'b0;
      pwr_oe_q <= IRQ_PIN_MODE && IRQ_PENDING;
      // Synchronised level is high while the pin is held low.
      pd_q <= !IRQ_PIN_MODE && s_lvl[`SY_PWR];
    end
  end

  assign RX_CLK_PIN_OUT = clk_pin_q;
  assign RX_CLK_PIN_OE = clk_oe_q;
  assign RX_D = rx_d_q;
  assign RX_DV = rx_dv_q;
  assign RX_ER = rx_er_q;
  assign MDIO_OUT = mdio_out_q;
  assign MDIO_OE = mdio_oe_q;
  assign MGMT_BIT = mgmt_bit_q;
  assign MGMT_BIT_VALID = mgmt_vld_q;
  assign POWER_DOWN_OR_IRQ_PIN_OUT = pwr_out_q;
  assign POWER_DOWN_OR_IRQ_PIN_OE = pwr_oe_q;
  assign POWER_DOWN = pd_q;

  // Checks; they assume CE stays high, since a low CE stretches time.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN || !CE);

  rx_clk_period_a: assert property (
    rx_rise |-> ##16 rx_rise
  ) else $error("receive clock period is not 16 cycles");

  data_on_rise_a: assert property (
    (mode == MODE_MII && $stable(mode) && $changed(rx_d_q)) |->
      $rose(clk_pin_q)
  ) else $error("receive data changed away from clock rise");

  idle_data_zero_a: assert property (
    (mode == MODE_MII && !rx_dv_q) |-> (rx_d_q == 4'h0)
  ) else $error("receive data not zero while idle");

  rmii_two_bits_a: assert property (
    (is_rmii && $past(is_rmii) && $stable(mode)) |-> (rx_d_q[3:2] == 2'h0)
  ) else $error("upper data bits used in RMII");

  crs_dv_a: assert property (
    (tick_r && is_rmii && !REPEATER_SEL && SYM_CARRIER) |=> rx_dv_q
  ) else $error("carrier not shown on RMII valid pin");

  repeater_dv_a: assert property (
    (tick_r && is_rmii && REPEATER_SEL && !hold_full_q) |=> !rx_dv_q
  ) else $error("repeater valid pin shows carrier");

  rgmii_ctrl_er_a: assert property (
    (tick_f && mode == MODE_RGMII) |=> (rx_dv_q == $past(rgmii_er_q))
  ) else $error("RGMII control does not carry error on fall");

  mii_err_report_a: assert property (
    (SYM_ERR && mode == MODE_MII) |->
      ##[1:17] (rx_er_q || mode != MODE_MII)
  ) else $error("error not reported within a clock period");

  rgmii_no_er_a: assert property (
    (mode == MODE_RGMII && $past(mode) == MODE_RGMII) |-> !rx_er_q
  ) else $error("error pin used in RGMII");

  slave_clk_off_a: assert property (
    (mode == MODE_RMII_SLAVE) |=> !clk_oe_q
  ) else $error("receive clock pin driven in RMII slave");

  pin_irq_drive_a: assert property (
    (IRQ_PIN_MODE && IRQ_PENDING) |=> (pwr_oe_q && !pwr_out_q)
  ) else $error("interrupt not pulled low");

  pin_pd_only_a: assert property (
    !$past(IRQ_PIN_MODE) |-> !pwr_oe_q
  ) else $error("power-down pin driven as output");

  power_down_a: assert property (
    (!IRQ_PIN_MODE && s_lvl[`SY_PWR]) |=> pd_q
  ) else $error("low power-down pin did not power down");

  mdio_turn_a: assert property (
    $rose(mdio_oe_q) |-> $past(MGMT_DRIVE && s_fall[`SY_MDC])
  ) else $error("management line driven unasked");

  frame_mii_c: cover property (mode == MODE_MII && rx_dv_q ##16 rx_dv_q);
  rmii_pair_c: cover property (is_rmii && consume);
  rgmii_err_c: cover property (tick_f && mode == MODE_RGMII && rgmii_er_q);
  irq_pin_c: cover property (pwr_oe_q);

endmodule : phy_receive_mac_interface

// ---- hdl/phy_rx_consts.svh ----
// Timing counts and field widths for the receive-side MAC interface.
// Assumes the core clock runs at CLK_KHZ and that includers use the macros.
`ifndef PHY_RX_CONSTS_SVH
`define PHY_RX_CONSTS_SVH

// Core clock rate in kHz (40 MHz, 25 ns period).
`define CLK_KHZ 40000
// Recovered receive clock for MII and RGMII at 10 Mb/s, in kHz.
`define RXCLK_KHZ 2500
// RMII master reference clock, in kHz.
`define RMII_REF_KHZ 50000
// Fastest management clock the station may use, in kHz.
`define MDC_MAX_KHZ 1750

// Half periods in core cycles; a longest time rounds down, never below one.
`define RXCLK_HALF ((`CLK_KHZ) / (2 * (`RXCLK_KHZ)))
`define RMII_HALF_RAW ((`CLK_KHZ) / (2 * (`RMII_REF_KHZ)))
`define RMII_HALF ((`RMII_HALF_RAW) > 0 ? (`RMII_HALF_RAW) : 1)
// Least management clock period in core cycles, rounded up.
`define MDC_MIN_CYC (((`CLK_KHZ) + (`MDC_MAX_KHZ) - 1) / (`MDC_MAX_KHZ))

// Data path widths: a nibble in MII/RGMII, a dibit in RMII.
`define NIB_W 4
`define DIBIT_W 2
// Number of pin inputs that cross into the core clock domain.
`define SYNC_W 4
// Bit positions of the synchronised pins.
`define SY_MDC 0
`define SY_MDIO 1
`define SY_REF 2
`define SY_PWR 3

`endif

// ---- hdl/phy_rx_pkg.sv ----
// Types shared by the receive-side MAC interface modules.
// Assumes nothing of its surroundings.
package phy_rx_pkg;

  // MAC interface mode, as chosen by strap or register logic.
  typedef enum logic [1:0] {
    MODE_MII = 2'b00,
    MODE_RMII_MASTER = 2'b01,
    MODE_RMII_SLAVE = 2'b10,
    MODE_RGMII = 2'b11
  } mac_mode_e;

  // Which half of a nibble goes out next in RMII mode.
  typedef enum logic [0:0] {
    PH_LOW = 1'b0,
    PH_HIGH = 1'b1
  } dibit_phase_e;

endpackage : phy_rx_pkg

// ---- hdl/pin_sync.sv ----
// Two-flop synchronisers with edge detection for a group of pin inputs.
// Assumes the inputs are asynchronous to CLK; edges come from stage two.
module pin_sync #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_q;
      logic sync_q;
      logic last_q;
      // The first stage feeds only the second, so it may go metastable.
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
          last_q <= 1'b0;
        end else if (ce) begin
          meta_q <= pin_in[i];
          sync_q <= meta_q;
          last_q <= sync_q;
        end
      end
      assign level[i] = sync_q;
      assign rise[i] = sync_q & ~last_q;
      assign fall[i] = ~sync_q & last_q;
    end
  endgenerate

endmodule : pin_sync

// ---- hdl/clk_div.sv ----
// Clock divider producing a square wave and edge strobes on the core clock.
// Assumes HALF is at least one core cycle.
module clk_div #(
  parameter int HALF = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  output logic clk_q,
  output logic rise_q,
  output logic fall_q
);

  localparam int CW = (HALF > 1) ? $clog2(HALF) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF - 1);
  logic [CW-1:0] cnt_q;

  // The strobes are high in the same cycle that clk_q shows the new level.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
      clk_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else if (ce) begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      if (cnt_q == LAST) begin
        cnt_q <= '0;
        clk_q <= ~clk_q;
        rise_q <= ~clk_q;
        fall_q <= clk_q;
      end else begin
        cnt_q <= cnt_q + CW'(1);
      end
    end
  end

endmodule : clk_div

// ---- dv/mgmt_station.sv ----
// Behavioural management station on the far side of the management pins.
// Assumes the bench calls clock_bit for each bit of a frame it wants sent.
module mgmt_station (
  output logic mdc,
  output logic mdio_level,
  input wire logic dut_out,
  input wire logic dut_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // Half period of 500 ns keeps the clock at 1 MHz, below the limit.
  localparam int HALF_NS = 500;
  logic drv;
  logic bit_q;

  // The clock stands low outside frames.
  initial begin
    mdc = 1'b0;
    drv = 1'b0;
    bit_q = 1'b0;
  end

  // Wire resolution: one driver at a time, X if both drive, else the pull-up holds it high.
  always_comb begin
    if (dut_oe && drv) begin
      mdio_level = 1'bx;
    end else if (dut_oe) begin
      mdio_level = dut_out;
    end else if (drv) begin
      mdio_level = bit_q;
    end else begin
      mdio_level = 1'b1;
    end
  end

  // One clock period; the station drives the line unless told to let go.
  task automatic clock_bit(input logic b, input logic let_go);
    drv = !let_go;
    bit_q = b;
    #(HALF_NS);
    mdc = 1'b1;
    #(HALF_NS);
    mdc = 1'b0;
  endtask : clock_bit
endmodule : mgmt_station

// ---- dv/testbench.sv ----
// Self-checking bench for the receive-side MAC interface.
// Assumes the design files and mgmt_station are compiled before it.
module testbench
  import phy_rx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK, RESETN, CE, REPEATER_SEL, SYM_VALID, SYM_ERR, SYM_CARRIER;
  logic RMII_REF_IN, MGMT_DRIVE, MGMT_OUT_BIT, IRQ_PIN_MODE, IRQ_PENDING;
  logic [1:0] MAC_MODE;
  logic [3:0] SYM_DATA, RX_D, n, e;
  logic RX_CLK_PIN_OUT, RX_CLK_PIN_OE, RX_DV, RX_ER, MDIO_OUT, MDIO_OE;
  logic MGMT_BIT, MGMT_BIT_VALID, POWER_DOWN, pd_out, pd_oe;
  logic pd_low, ref_on, mdc, mdio_level, pin_level;
  logic [3:0] exp_q[$];
  logic mbits[$];
  int failures, checked, k;

  phy_receive_mac_interface DUT (.CLK(CLK), .RESETN(RESETN), .CE(CE),
    .MAC_MODE(MAC_MODE), .REPEATER_SEL(REPEATER_SEL),
    .SYM_VALID(SYM_VALID), .SYM_DATA(SYM_DATA), .SYM_ERR(SYM_ERR),
    .SYM_CARRIER(SYM_CARRIER), .RMII_REF_IN(RMII_REF_IN),
    .RX_CLK_PIN_OUT(RX_CLK_PIN_OUT), .RX_CLK_PIN_OE(RX_CLK_PIN_OE),
    .RX_D(RX_D), .RX_DV(RX_DV), .RX_ER(RX_ER), .MDC(mdc),
    .MDIO_IN(mdio_level), .MDIO_OUT(MDIO_OUT), .MDIO_OE(MDIO_OE),
    .MGMT_DRIVE(MGMT_DRIVE), .MGMT_OUT_BIT(MGMT_OUT_BIT),
    .MGMT_BIT(MGMT_BIT), .MGMT_BIT_VALID(MGMT_BIT_VALID),
    .IRQ_PIN_MODE(IRQ_PIN_MODE), .IRQ_PENDING(IRQ_PENDING),
    .POWER_DOWN_OR_IRQ_PIN_IN(pin_level),
    .POWER_DOWN_OR_IRQ_PIN_OUT(pd_out), .POWER_DOWN_OR_IRQ_PIN_OE(pd_oe),
    .POWER_DOWN(POWER_DOWN));

  mgmt_station st (.mdc(mdc), .mdio_level(mdio_level), .dut_out(MDIO_OUT),
    .dut_oe(MDIO_OE));

  // Open-drain shared pin with its weak pull-up.
  assign pin_level = pd_oe ? pd_out : (pd_low ? 1'b0 : 1'b1);

  // Core clock, 25 ns period.
  always #12.5 CLK = ~CLK;

  // Reference clock for slave mode; 200 ns period with an unrelated phase.
  initial begin
    RMII_REF_IN = 1'b0;
    #14.5;
    forever #100 RMII_REF_IN = ref_on ? ~RMII_REF_IN : 1'b0;
  end

  // Record every management bit the design reports, sampled mid-cycle.
  always @(negedge CLK) if (MGMT_BIT_VALID === 1'b1) mbits.push_back(MGMT_BIT);

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int c);
    repeat (c) @(posedge CLK);
    #2;
  endtask : tick

  // One symbol from the decoder; the model queues what must come out.
  task automatic send(input logic v, input logic [3:0] d, input logic er);
    SYM_VALID = v;
    SYM_DATA = d;
    SYM_ERR = er;
    if (v) exp_q.push_back(d);
    tick(1);
    SYM_VALID = 1'b0;
    SYM_ERR = 1'b0;
  endtask : send

  // Bounded wait for a rising receive clock; c counts the cycles taken.
  task automatic wait_rise(output int c);
    logic p;
    c = 0;
    do begin
      p = RX_CLK_PIN_OUT;
      tick(1);
      c++;
    end while (!(p === 1'b0 && RX_CLK_PIN_OUT === 1'b1) && c < 64);
  endtask : wait_rise

  task automatic final_report;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  // Watchdog: the tests take well under a quarter of this span.
  initial begin
    #600000;
    failures++;
    final_report();
  end

  // Main sequence.
  initial begin
    CLK = 0; RESETN = 0; CE = 1; MAC_MODE = MODE_MII; REPEATER_SEL = 0;
    SYM_VALID = 0; SYM_DATA = 4'h0; SYM_ERR = 0; SYM_CARRIER = 0;
    MGMT_DRIVE = 0; MGMT_OUT_BIT = 0; IRQ_PIN_MODE = 0; IRQ_PENDING = 0;
    pd_low = 0; ref_on = 0; failures = 0; checked = 0;
    void'($urandom(81522));
    tick(8);
    check({RX_DV, RX_ER, RX_D}, 0);
    check({RX_CLK_PIN_OE, pd_oe, POWER_DOWN}, 0);
    RESETN = 1;
    tick(20);
    check({pd_oe, POWER_DOWN}, 0);
    // MII: a nibble per 16-cycle clock, then an error while idle.
    wait_rise(k);
    n = 4'($urandom_range(15));
    send(1'b1, n, 1'b1);
    wait_rise(k);
    check(k, 15);
    e = exp_q.pop_front();
    check({RX_DV, RX_ER, RX_D, RX_CLK_PIN_OE}, {2'b11, e, 1'b1});
    wait_rise(k);
    check(k, 16);
    check({RX_DV, RX_ER, RX_D}, 0);
    send(1'b0, 4'h0, 1'b1);
    wait_rise(k);
    check({RX_DV, RX_ER}, 2'b01);
    wait_rise(k);
    check(RX_ER, 0);
    // RMII master: carrier-sense and valid share the pin, dibits low first.
    MAC_MODE = MODE_RMII_MASTER;
    SYM_CARRIER = 1;
    tick(20);
    wait_rise(k);
    wait_rise(k);
    check({RX_CLK_PIN_OE, 4'(k)}, {1'b1, 4'h2});
    n = 4'($urandom_range(15));
    send(1'b1, n, 1'b1);
    wait_rise(k);
    e = exp_q.pop_front();
    check({RX_DV, RX_ER, RX_D}, {2'b11, 2'b00, e[1:0]});
    wait_rise(k);
    check({RX_ER, RX_D}, {3'b000, e[3:2]});
    wait_rise(k);
    check(RX_DV, 1);
    REPEATER_SEL = 1;
    tick(4);
    wait_rise(k);
    check(RX_DV, 0);
    send(1'b1, 4'($urandom_range(15)), 1'b0);
    wait_rise(k);
    e = exp_q.pop_front();
    check({RX_DV, RX_D}, {3'b100, e[1:0]});
    REPEATER_SEL = 0;
    SYM_CARRIER = 0;
    // RMII slave: pin undriven, data follows the outside reference clock.
    MAC_MODE = MODE_RMII_SLAVE;
    ref_on = 1;
    tick(30);
    check(RX_CLK_PIN_OE, 0);
    send(1'b1, 4'($urandom_range(15)), 1'b0);
    k = 0;
    while (RX_DV !== 1'b1 && k < 40) begin
      tick(1);
      k++;
    end
    tick(3);
    e = exp_q.pop_front();
    check({RX_DV, RX_D}, {3'b100, e[1:0]});
    tick(8);
    check(RX_D, {2'b00, e[3:2]});
    ref_on = 0;
    // RGMII: valid on the rise, error flag on the fall, error pin unused.
    MAC_MODE = MODE_RGMII;
    tick(40);
    wait_rise(k);
    n = 4'($urandom_range(15));
    send(1'b1, n, 1'b1);
    wait_rise(k);
    check(k, 15);
    e = exp_q.pop_front();
    check({RX_DV, RX_ER, RX_D}, {2'b10, e});
    tick(8);
    check({RX_CLK_PIN_OUT, RX_DV, RX_ER}, 3'b010);
    wait_rise(k);
    tick(8);
    check({RX_DV, RX_ER}, 0);
    // Clock enable low freezes the divider; the rise comes 10 cycles late.
    wait_rise(k);
    CE = 0;
    tick(10);
    check(RX_CLK_PIN_OUT, 1);
    CE = 1;
    wait_rise(k);
    check(k, 16);
    // Management: station writes bits, then the design drives the line.
    for (int i = 0; i < 4; i++) begin
      n = 4'($urandom_range(15));
      mbits.delete();
      st.clock_bit(n[0], 1'b0);
      tick(5);
      check({4'(mbits.size()), mbits[0]}, {4'h1, n[0]});
      MGMT_DRIVE = 1;
      MGMT_OUT_BIT = n[1];
      st.clock_bit(1'b0, 1'b1);
      tick(5);
      check({MDIO_OE, MDIO_OUT, mdio_level}, {1'b1, n[1], n[1]});
      MGMT_DRIVE = 0;
      st.clock_bit(1'b0, 1'b1);
      tick(5);
      check({MDIO_OE, mdio_level}, 2'b01);
    end
    // Shared pin: power-down input by default, open-drain interrupt later.
    pd_low = 1;
    tick(6);
    check(POWER_DOWN, 1);
    pd_low = 0;
    tick(6);
    check(POWER_DOWN, 0);
    IRQ_PIN_MODE = 1;
    IRQ_PENDING = 1;
    tick(6);
    check({pd_oe, pd_out, pin_level, POWER_DOWN}, 4'h8);
    IRQ_PENDING = 0;
    tick(4);
    check({pd_oe, pin_level}, 2'b01);
    final_report();
  end
endmodule : testbench
